/* File: iosad_pkg.sv */
// constants, register table and operation codes for the io space access decoder
package iosad_pkg;

  localparam int IOSAD_NREG = 48;

  // offset between direct io address and data-space address
  localparam logic [7:0] IOSAD_IO_OFFSET = 8'h20;
  localparam logic [7:0] IOSAD_IO_LAST = 8'h3f;
  localparam logic [7:0] IOSAD_BIT_LAST = 8'h1f;
  localparam logic [7:0] IOSAD_RESET_VAL = 8'h00;

  typedef enum logic [2:0] {
    io_in_op = 3'b000,
    io_out_op = 3'b001,
    direct_load_op = 3'b010,
    direct_store_op = 3'b011,
    set_single_bit_op = 3'b100,
    clear_single_bit_op = 3'b101,
    skip_if_bit_set_op = 3'b110,
    skip_if_bit_clear_op = 3'b111
  } iosad_op_t;

  typedef enum logic [1:0] {
    kind_pin = 2'b00,
    kind_rw = 2'b01,
    kind_w1c = 2'b10
  } iosad_kind_t;

  // table index of selected registers
  localparam int IDX_PORT_A_PIN = 0;
  localparam int IDX_PORT_A_DIR = 1;
  localparam int IDX_PORT_A_OUT = 2;
  localparam int IDX_PORT_B_PIN = 3;
  localparam int IDX_PORT_B_DIR = 4;
  localparam int IDX_PORT_B_OUT = 5;
  localparam int IDX_PORT_C_PIN = 6;
  localparam int IDX_PORT_C_DIR = 7;
  localparam int IDX_PORT_C_OUT = 8;
  localparam int IDX_PORT_D_PIN = 9;
  localparam int IDX_PORT_D_DIR = 10;
  localparam int IDX_PORT_D_OUT = 11;
  localparam int IDX_TIMER0_FLAGS = 12;
  localparam int IDX_TIMER1_FLAGS = 13;
  localparam int IDX_TIMER2_FLAGS = 14;
  localparam int IDX_PIN_CHANGE_FLAGS = 15;
  localparam int IDX_EXT_IRQ_FLAGS = 16;
  localparam int IDX_SCRATCH_0 = 18;

  // data-space address of each register, index 0 first
  localparam logic [7:0] IOSAD_REG_ADDR [IOSAD_NREG] = '{
    8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
    8'h28, 8'h29, 8'h2a, 8'h2b, 8'h35, 8'h36, 8'h37, 8'h3b,
    8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h43,
    8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h4a, 8'h4b, 8'h4c,
    8'h4d, 8'h4e, 8'h50, 8'h51, 8'h53, 8'h54, 8'h55, 8'h57,
    8'h60, 8'h61, 8'h64, 8'h66, 8'h68, 8'h69, 8'h6b, 8'h6c};

  // implemented bit positions; the rest read zero and ignore writes
  localparam logic [7:0] IOSAD_REG_MASK [IOSAD_NREG] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h07, 8'h27, 8'h07, 8'h0f,
    8'h07, 8'h07, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h0f, 8'h83,
    8'hf3, 8'hcf, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hc1, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h1f, 8'h93, 8'hff,
    8'hff, 8'h8f, 8'hef, 8'hff, 8'h0f, 8'h3f, 8'hff, 8'hff};

  localparam iosad_kind_t IOSAD_REG_KIND [IOSAD_NREG] = '{
    kind_pin, kind_rw, kind_rw, kind_pin, kind_rw, kind_rw, kind_pin, kind_rw,
    kind_rw, kind_pin, kind_rw, kind_rw, kind_w1c, kind_w1c, kind_w1c, kind_w1c,
    kind_w1c, kind_rw, kind_rw, kind_rw, kind_rw, kind_rw, kind_rw, kind_rw,
    kind_rw, kind_rw, kind_rw, kind_rw, kind_rw, kind_rw, kind_rw, kind_rw,
    kind_rw, kind_rw, kind_rw, kind_rw, kind_rw, kind_rw, kind_rw, kind_rw,
    kind_rw, kind_rw, kind_rw, kind_rw, kind_rw, kind_rw, kind_rw, kind_rw};

endpackage : iosad_pkg

/* File: iosad_decoder.sv */
// io space access decoder: register file behind the core's io and data-space accesses
`timescale 1ns/1ps

module iosad_decoder
  import iosad_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic acc_valid,
  input wire iosad_op_t acc_op,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic [2:0] acc_bit,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  input wire logic [7:0] port_c_pins,
  input wire logic [7:0] port_d_pins,
  input wire logic [7:0] timer0_flag_set,
  input wire logic [7:0] timer1_flag_set,
  input wire logic [7:0] timer2_flag_set,
  input wire logic [7:0] pin_change_flag_set,
  input wire logic [7:0] external_irq_flag_set,
  output logic acc_done_r,
  output logic [7:0] acc_rdata_r,
  output logic acc_skip_r,
  output logic acc_fault_r,
  output logic [7:0] port_a_dir_r,
  output logic [7:0] port_a_out_r,
  output logic [7:0] port_b_dir_r,
  output logic [7:0] port_b_out_r,
  output logic [7:0] port_c_dir_r,
  output logic [7:0] port_c_out_r,
  output logic [7:0] port_d_dir_r,
  output logic [7:0] port_d_out_r
);

  typedef struct packed {
    logic [IOSAD_NREG-1:0][7:0] regs;
    logic done;
    logic [7:0] rdata;
    logic skip;
    logic fault;
  } iosad_state_t;

  iosad_state_t st_r;
  iosad_state_t st_nxt;

  logic [IOSAD_NREG-1:0][7:0] hw_set;
  logic [7:0] daddr;
  logic range_ok;
  logic hit;
  logic [5:0] idx;
  logic [7:0] cur_val;
  logic [7:0] bit_sel;
  logic [7:0] wr_val;
  logic is_write;

  // table search; a miss means an unused location
  function automatic logic [6:0] iosad_lookup(input logic [7:0] a);
    logic [6:0] res;
    res = 7'h00;
    for (int i = 0; i < IOSAD_NREG; i++) begin
      if (IOSAD_REG_ADDR[i] == a) begin
        res = {1'b1, 6'(i)};
      end
    end
    return res;
  endfunction : iosad_lookup

  // write effect on one register
  function automatic logic [7:0] iosad_apply(input int i, input logic [7:0] old, input logic [7:0] wd);
    logic [7:0] res;
    res = old;
    case (IOSAD_REG_KIND[i])
      kind_rw: res = wd & IOSAD_REG_MASK[i];
      kind_w1c: res = old & ~wd & IOSAD_REG_MASK[i];
      default: res = old;
    endcase
    return res;
  endfunction : iosad_apply

  always_comb begin
    hw_set = '0;
    hw_set[IDX_TIMER0_FLAGS] = timer0_flag_set;
    hw_set[IDX_TIMER1_FLAGS] = timer1_flag_set;
    hw_set[IDX_TIMER2_FLAGS] = timer2_flag_set;
    hw_set[IDX_PIN_CHANGE_FLAGS] = pin_change_flag_set;
    hw_set[IDX_EXT_IRQ_FLAGS] = external_irq_flag_set;
  end

  // address translation per operation
  always_comb begin
    daddr = acc_addr;
    range_ok = 1'b1;
    case (acc_op)
      io_in_op, io_out_op: begin
        range_ok = (acc_addr <= IOSAD_IO_LAST);
        daddr = acc_addr + IOSAD_IO_OFFSET;
      end
      set_single_bit_op, clear_single_bit_op, skip_if_bit_set_op, skip_if_bit_clear_op: begin
        range_ok = (acc_addr <= IOSAD_BIT_LAST);
        daddr = acc_addr + IOSAD_IO_OFFSET;
      end
      default: begin
        // loads and stores reach the whole map, extended region included
        range_ok = (acc_addr >= IOSAD_IO_OFFSET);
        daddr = acc_addr;
      end
    endcase
  end

  always_comb begin
    {hit, idx} = iosad_lookup(daddr);
    cur_val = hit ? (st_r.regs[idx] & IOSAD_REG_MASK[idx]) : 8'h00;
    bit_sel = 8'h01 << acc_bit;
    is_write = (acc_op == io_out_op) || (acc_op == direct_store_op) ||
               (acc_op == set_single_bit_op) || (acc_op == clear_single_bit_op);
    case (acc_op)
      // whole register written back, set flags go out as ones
      set_single_bit_op: wr_val = cur_val | bit_sel;
      clear_single_bit_op: wr_val = cur_val & ~bit_sel;
      default: wr_val = acc_wdata;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = acc_valid;
    st_nxt.skip = 1'b0;
    st_nxt.fault = 1'b0;
    st_nxt.rdata = 8'h00;
    if (acc_valid) begin
      if (!range_ok) begin
        st_nxt.fault = 1'b1;
      end else if (is_write) begin
        // writes to unused locations are dropped and flagged
        if (hit) begin
          st_nxt.regs[idx] = iosad_apply(int'(idx), st_r.regs[idx], wr_val);
        end else begin
          st_nxt.fault = 1'b1;
        end
      end else begin
        st_nxt.rdata = cur_val;
        // skip answer for the chosen bit
        if (acc_op == skip_if_bit_set_op) begin
          st_nxt.skip = cur_val[acc_bit];
        end else if (acc_op == skip_if_bit_clear_op) begin
          st_nxt.skip = !cur_val[acc_bit];
        end
      end
    end
    // hardware set comes last so it wins over a same-cycle clear
    for (int i = 0; i < IOSAD_NREG; i++) begin
      if (IOSAD_REG_KIND[i] == kind_w1c) begin
        st_nxt.regs[i] = st_nxt.regs[i] | (hw_set[i] & IOSAD_REG_MASK[i]);
      end
    end
    // pin readback is one cycle behind the pins
    st_nxt.regs[IDX_PORT_A_PIN] = port_a_pins;
    st_nxt.regs[IDX_PORT_B_PIN] = port_b_pins;
    st_nxt.regs[IDX_PORT_C_PIN] = port_c_pins;
    st_nxt.regs[IDX_PORT_D_PIN] = port_d_pins;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r.regs <= {IOSAD_NREG{IOSAD_RESET_VAL}};
      st_r.done <= 1'b0;
      st_r.rdata <= 8'h00;
      st_r.skip <= 1'b0;
      st_r.fault <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign acc_done_r = st_r.done;
  assign acc_rdata_r = st_r.rdata;
  assign acc_skip_r = st_r.skip;
  assign acc_fault_r = st_r.fault;
  assign port_a_dir_r = st_r.regs[IDX_PORT_A_DIR];
  assign port_a_out_r = st_r.regs[IDX_PORT_A_OUT];
  assign port_b_dir_r = st_r.regs[IDX_PORT_B_DIR];
  assign port_b_out_r = st_r.regs[IDX_PORT_B_OUT];
  assign port_c_dir_r = st_r.regs[IDX_PORT_C_DIR];
  assign port_c_out_r = st_r.regs[IDX_PORT_C_OUT];
  assign port_d_dir_r = st_r.regs[IDX_PORT_D_DIR];
  assign port_d_out_r = st_r.regs[IDX_PORT_D_OUT];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic bitop_req;
  assign bitop_req = acc_valid && acc_op[2];

  chk_bit_range_refuse: assert property (
    bitop_req && (acc_addr > 8'h1f) && (acc_addr <= 8'h3f)
    |=> acc_fault_r && acc_done_r && !acc_skip_r && (st_r.regs == $past(st_r.regs) || $past(|hw_set))
  ) else $error("bit operation above 0x1f was not refused");

  chk_skip_set_bit: assert property (
    acc_valid && acc_op == skip_if_bit_set_op && acc_addr <= 8'h1f
    |=> acc_skip_r == acc_rdata_r[$past(acc_bit)]
  ) else $error("skip-if-set answer does not match the tested bit");

  chk_skip_clr_bit: assert property (
    acc_valid && acc_op == skip_if_bit_clear_op && acc_addr == 8'h1e
    |=> acc_skip_r == !$past(st_r.regs[IDX_SCRATCH_0][acc_bit])
  ) else $error("skip-if-clear answer wrong");

  chk_flag_zero_keep: assert property (
    acc_valid && acc_op == io_out_op && acc_addr == 8'h15 && acc_wdata == 8'h00 && timer0_flag_set == 8'h00
    |=> st_r.regs[IDX_TIMER0_FLAGS] == $past(st_r.regs[IDX_TIMER0_FLAGS])
  ) else $error("writing zero changed a status flag");

  chk_flag_one_clear: assert property (
    acc_valid && acc_op == direct_store_op && acc_addr == 8'h35 && (acc_wdata & 8'h07) == 8'h07 && timer0_flag_set == 8'h00
    |=> st_r.regs[IDX_TIMER0_FLAGS] == 8'h00
  ) else $error("writing ones did not clear the flags");

  chk_set_wins_clear: assert property (
    acc_valid && acc_op == direct_store_op && acc_addr == 8'h35 && (acc_wdata & 8'h07) == 8'h07
    |=> st_r.regs[IDX_TIMER0_FLAGS] == ($past(timer0_flag_set) & 8'h07)
  ) else $error("hardware flag set lost against clear");

  chk_rmw_clears_flags: assert property (
    acc_valid && acc_op == set_single_bit_op && acc_addr == 8'h15 && timer0_flag_set == 8'h00
    |=> st_r.regs[IDX_TIMER0_FLAGS] == 8'h00
  ) else $error("single-bit set did not clear flags read as set");

  chk_io_range_refuse: assert property (
    acc_valid && (acc_op == io_in_op || acc_op == io_out_op) && acc_addr > 8'h3f
    |=> acc_fault_r && acc_rdata_r == 8'h00
  ) else $error("io access above 0x3f was not refused");

  chk_io_data_alias: assert property (
    acc_valid && acc_op == io_out_op && acc_addr == 8'h1e
    ##2 acc_valid && acc_op == direct_load_op && acc_addr == 8'h3e
    |=> acc_rdata_r == $past(acc_wdata, 3)
  ) else $error("io write not visible at data address plus 0x20");

  chk_ext_store_load: assert property (
    acc_valid && acc_op == direct_store_op && acc_addr == 8'h66
    ##2 acc_valid && acc_op == direct_load_op && acc_addr == 8'h66
    |=> acc_rdata_r == $past(acc_wdata, 3) && !acc_fault_r
  ) else $error("extended region store then load mismatch");

  chk_unused_reads_zero: assert property (
    acc_valid && acc_op == direct_load_op && acc_addr == 8'h70
    |=> acc_rdata_r == 8'h00 ##0 acc_done_r
  ) else $error("unused location did not read zero");

  chk_done_follows_req: assert property (
    acc_valid |=> acc_done_r ##1 (acc_done_r == $past(acc_valid))
  ) else $error("done does not follow request by one cycle");

  cov_bit_set_ok: cover property (acc_valid && acc_op == set_single_bit_op && acc_addr <= 8'h1f ##1 !acc_fault_r);
  cov_skip_taken: cover property (acc_valid && acc_op == skip_if_bit_clear_op ##1 acc_skip_r);
  cov_ext_store: cover property (acc_valid && acc_op == direct_store_op && acc_addr >= 8'h60 ##1 !acc_fault_r);
  cov_flag_race: cover property (acc_valid && acc_op == io_out_op && acc_addr == 8'h1c && |external_irq_flag_set);

endmodule : iosad_decoder

/* File: iosad_core_model.sv */
// processor core model issuing io, data-space and bit accesses
`timescale 1ns/1ps

module iosad_core_model
  import iosad_pkg::*;
(
  input wire logic core_clk,
  input wire logic rule_break,
  input wire logic acc_done_r,
  input wire logic [7:0] acc_rdata_r,
  input wire logic acc_skip_r,
  input wire logic acc_fault_r,
  output logic acc_valid,
  output iosad_op_t acc_op,
  output logic [7:0] acc_addr,
  output logic [7:0] acc_wdata,
  output logic [2:0] acc_bit
);
  initial begin
    acc_valid = 1'b0;
    acc_op = io_in_op;
    acc_addr = 8'h00;
    acc_wdata = 8'h00;
    acc_bit = 3'h0;
  end

  // implemented bits at a data-space address, zero where unused
  function automatic logic [7:0] bits_at(input logic [7:0] da);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < IOSAD_NREG; i++) begin
      if (IOSAD_REG_ADDR[i] == da) begin
        m = IOSAD_REG_MASK[i];
      end
    end
    return m;
  endfunction : bits_at

  task automatic access(input iosad_op_t op, input logic [7:0] addr, input logic [7:0] wd, input logic [2:0] b,
                        output logic [7:0] rd, output logic sk, output logic flt, output logic dn);
    logic [7:0] da;
    da = (op inside {direct_load_op, direct_store_op}) ? addr : addr + IOSAD_IO_OFFSET;
    rd = 8'h00;
    sk = 1'b0;
    flt = 1'b1;
    dn = 1'b1;
    if (!rule_break && bits_at(da) == 8'h00 &&
        op inside {io_out_op, direct_store_op, set_single_bit_op, clear_single_bit_op}) begin
      return;
    end
    if (!rule_break) begin
      wd = wd & bits_at(da);
    end
    @(posedge core_clk);
    #1;
    acc_valid = 1'b1;
    acc_op = op;
    acc_addr = addr;
    acc_wdata = wd;
    acc_bit = b;
    @(posedge core_clk);
    #1;
    // released address and write data lines flip so a stale value never passes
    acc_valid = 1'b0;
    acc_addr = ~acc_addr;
    acc_wdata = ~acc_wdata;
    rd = acc_rdata_r;
    sk = acc_skip_r;
    flt = acc_fault_r;
    dn = acc_done_r;
  endtask : access
endmodule : iosad_core_model

/* File: tb_top.sv */
// self-checking bench for the io space access decoder
`timescale 1ns/1ps

module tb_top
  import iosad_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rule_break = 1'b0;
  logic acc_valid, acc_done_r, acc_skip_r, acc_fault_r, sk, flt, dn;
  iosad_op_t acc_op;
  logic [7:0] acc_addr, acc_wdata, acc_rdata_r, rd, m, a;
  logic [2:0] acc_bit;
  logic [7:0] pins [4];
  logic [7:0] fs [5];
  logic [7:0] dir_o [4];
  logic [7:0] out_o [4];
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;

  always #5 core_clk = ~core_clk;

  iosad_decoder uut (
    .core_clk, .rst_n, .acc_valid, .acc_op, .acc_addr, .acc_wdata, .acc_bit,
    .port_a_pins(pins[0]), .port_b_pins(pins[1]), .port_c_pins(pins[2]), .port_d_pins(pins[3]),
    .timer0_flag_set(fs[0]), .timer1_flag_set(fs[1]), .timer2_flag_set(fs[2]),
    .pin_change_flag_set(fs[3]), .external_irq_flag_set(fs[4]),
    .acc_done_r, .acc_rdata_r, .acc_skip_r, .acc_fault_r,
    .port_a_dir_r(dir_o[0]), .port_a_out_r(out_o[0]), .port_b_dir_r(dir_o[1]), .port_b_out_r(out_o[1]),
    .port_c_dir_r(dir_o[2]), .port_c_out_r(out_o[2]), .port_d_dir_r(dir_o[3]), .port_d_out_r(out_o[3])
  );

  iosad_core_model core (
    .core_clk, .rule_break, .acc_done_r, .acc_rdata_r, .acc_skip_r, .acc_fault_r,
    .acc_valid, .acc_op, .acc_addr, .acc_wdata, .acc_bit
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic acc(input iosad_op_t op, input logic [7:0] ad, input logic [7:0] wd, input logic [2:0] b);
    core.access(op, ad, wd, b, rd, sk, flt, dn);
    check("done", {7'h0, dn}, 8'h01);
  endtask : acc

  task automatic rdchk(input iosad_op_t op, input logic [7:0] ad, input logic [7:0] e, input logic fe);
    acc(op, ad, 8'h00, 3'h0);
    check("read data", rd, e);
    check("fault", {7'h0, flt}, {7'h0, fe});
  endtask : rdchk

  task automatic pulse(input int i);
    fs[i] = 8'hff;
    @(posedge core_clk);
    #1;
    fs[i] = 8'h00;
  endtask : pulse

  // a hang counts as a mismatch
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    fs = '{default: 8'h00};
    pins = '{default: 8'h00};
    repeat (20) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      check("dir reset", dir_o[i], IOSAD_RESET_VAL);
      pins[i] = 8'h5a ^ 8'(i);
      rdchk(io_in_op, 8'(3 * i), 8'h5a ^ 8'(i), 1'b0);
      acc(io_out_op, 8'(3 * i + 1), 8'ha0 | 8'(i), 3'h0);
      check("dir", dir_o[i], 8'ha0 | 8'(i));
      acc(direct_store_op, 8'(3 * i + 8'h22), 8'h0f ^ 8'(i), 3'h0);
      check("out", out_o[i], 8'h0f ^ 8'(i));
      rdchk(direct_load_op, 8'(3 * i + 8'h21), 8'ha0 | 8'(i), 1'b0);
      acc(io_out_op, 8'(3 * i), 8'h00, 3'h0);
      rdchk(direct_load_op, 8'(3 * i + 8'h20), 8'h5a ^ 8'(i), 1'b0);
    end
    m = 8'h0e;
    for (int b = 0; b < 8; b++) begin
      acc(set_single_bit_op, 8'h05, 8'h00, 3'(b));
      m = m | (8'h01 << b);
      check("set bit", out_o[1], m);
      acc(skip_if_bit_set_op, 8'h05, 8'h00, 3'(b));
      check("skip set", {7'h0, sk}, 8'h01);
      acc(skip_if_bit_clear_op, 8'h05, 8'h00, 3'(b));
      check("no skip", {7'h0, sk}, 8'h00);
      acc(clear_single_bit_op, 8'h05, 8'h00, 3'(b ^ 1));
      m = m & ~(8'h01 << (b ^ 1));
      check("clear bit", out_o[1], m);
      acc(skip_if_bit_clear_op, 8'h05, 8'h00, 3'(b ^ 1));
      check("skip clear", {7'h0, sk}, 8'h01);
    end
    acc(set_single_bit_op, 8'h1f, 8'h00, 3'h5);
    rdchk(io_in_op, 8'h1f, 8'h20, 1'b0);
    rdchk(set_single_bit_op, 8'h20, 8'h00, 1'b1);
    rdchk(skip_if_bit_set_op, 8'h20, 8'h00, 1'b1);
    rdchk(direct_load_op, 8'h40, 8'h00, 1'b0);
    acc(io_out_op, 8'h37, 8'h3c, 3'h0);
    rdchk(direct_load_op, 8'h57, 8'h3c, 1'b0);
    rdchk(io_in_op, 8'h3f, 8'h00, 1'b0);
    rdchk(io_in_op, 8'h40, 8'h00, 1'b1);
    acc(direct_store_op, 8'h61, 8'hff, 3'h0);
    rdchk(direct_load_op, 8'h61, 8'h8f, 1'b0);
    rule_break = 1'b1;
    acc(io_out_op, 8'h41, 8'h00, 3'h0);
    check("fault", {7'h0, flt}, 8'h01);
    rdchk(io_in_op, 8'h41, 8'h00, 1'b1);
    rdchk(direct_load_op, 8'h61, 8'h8f, 1'b0);
    acc(direct_store_op, 8'h2c, 8'h55, 3'h0);
    check("fault", {7'h0, flt}, 8'h01);
    rdchk(direct_load_op, 8'h2c, 8'h00, 1'b0);
    acc(io_out_op, 8'h1d, 8'hff, 3'h0);
    rdchk(io_in_op, 8'h1d, 8'h07, 1'b0);
    rdchk(direct_load_op, 8'h1e, 8'h00, 1'b1);
    rule_break = 1'b0;
    for (int i = 0; i < 5; i++) begin
      m = IOSAD_REG_MASK[IDX_TIMER0_FLAGS + i];
      a = IOSAD_REG_ADDR[IDX_TIMER0_FLAGS + i] - IOSAD_IO_OFFSET;
      pulse(i);
      rdchk(io_in_op, a, m, 1'b0);
      acc(io_out_op, a, 8'h01, 3'h0);
      acc(io_out_op, a, 8'h00, 3'h0);
      rdchk(io_in_op, a, m & 8'hfe, 1'b0);
      acc(set_single_bit_op, a, 8'h00, 3'h0);
      rdchk(io_in_op, a, 8'h00, 1'b0);
      pulse(i);
      acc(clear_single_bit_op, a, 8'h00, 3'h0);
      rdchk(io_in_op, a, 8'h01, 1'b0);
    end
    // io write seen through data space, extended store and load, unused load
    acc(io_out_op, 8'h1e, 8'h96, 3'h0);
    rdchk(direct_load_op, 8'h3e, 8'h96, 1'b0);
    acc(direct_store_op, 8'h66, 8'h3c, 3'h0);
    rdchk(direct_load_op, 8'h66, 8'h3c, 1'b0);
    rdchk(direct_load_op, 8'h70, 8'h00, 1'b0);
    // store of ones clears, then a same-cycle hardware set wins
    acc(direct_store_op, 8'h35, 8'hff, 3'h0);
    rdchk(direct_load_op, 8'h35, 8'h00, 1'b0);
    fs[0] = 8'h01;
    acc(direct_store_op, 8'h35, 8'hff, 3'h0);
    fs[0] = 8'h00;
    rdchk(direct_load_op, 8'h35, 8'h01, 1'b0);
    complete_run();
  end
endmodule : tb_top
